//--- bench/scd_peer_model.sv
// bus peer with pull-ups that can clock scl as an outside master
`timescale 1ns/1ns
module scd_peer_model #(
  parameter int unsigned HALF = 31  // outside master half period
) (
  input  wire logic i_mclk,         // system clock
  input  wire logic i_resetn,       // sync reset, active low
  input  wire logic i_scl_oe,       // device pulls scl low
  input  wire logic i_run_master,   // peer clocks scl
  input  wire logic i_sda_low,      // peer pulls sda low
  output logic      o_scl,          // wired scl level
  output logic      o_sda           // wired sda level
);
  logic [7:0] cnt_q;
  logic       scl_low_q;
  // peer clock stands high outside its frames, a long bus free time
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || !i_run_master) begin
      cnt_q     <= 8'h00;
      scl_low_q <= 1'h0;
    end else if (cnt_q == 8'(HALF - 1)) begin
      cnt_q     <= 8'h00;
      scl_low_q <= ~scl_low_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // open drain: any party pulling low wins
  assign o_scl = ~(i_scl_oe | scl_low_q);
  assign o_sda = ~i_sda_low;
endmodule : scd_peer_model

//--- bench/test_scd_clock_divider.sv
// testbench for the serial clock divider and input filters
`timescale 1ns/1ns
module test_scd_clock_divider;
  logic                mclk = 1'h0;
  logic                resetn = 1'h0;
  scd_pkg::scd_ctrl_t  ctrl = '0;
  logic                enable = 1'h0;
  logic                sda_low = 1'h0;
  logic                run_master = 1'h0;
  logic                scl, sda, scl_o, scl_oe, half_tick, scl_rise;
  scd_pkg::scd_lines_t lines;
  int                  fails = 0;
  int                  check_count = 0;
  logic [31:0]         n, hi, seen;

  always #10 mclk = ~mclk;
  scd_clock_divider scd_clock_divider_inst (.i_mclk(mclk), .i_resetn(resetn),
    .i_ctrl(ctrl), .i_enable(enable), .i_scl(scl), .i_sda(sda), .o_scl_o(scl_o),
    .o_scl_oe(scl_oe), .o_half_tick(half_tick), .o_lines(lines), .o_scl_rise(scl_rise));
  scd_peer_model scd_peer_model_inst (.i_mclk(mclk), .i_resetn(resetn), .i_scl_oe(scl_oe),
    .i_run_master(run_master), .i_sda_low(sda_low), .o_scl(scl), .o_sda(sda));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic summarize;
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // settings change only while the divider is stopped
  task automatic set(input logic [5:0] m, input logic b, input logic [1:0] f, input logic mm);
    @(negedge mclk);
    enable = 1'h0;
    ctrl = '{m, b, scd_pkg::scd_filter_t'(f), mm};
    repeat (3) @(negedge mclk);
    enable = 1'h1;
  endtask : set
  // cycles between two half ticks; scl is pulled low in the second half
  task automatic half(input logic [5:0] m, input logic b);
    set(m, b, 2'h0, 1'h1);
    n = 0;
    while (half_tick !== 1'h1 && n < 2000) begin @(negedge mclk); n++; end
    cmp(scl_oe, 1'h1);
    n = 0;
    do begin @(negedge mclk); n++; end while (half_tick !== 1'h1 && n < 2000);
    cmp(n, (32'(m) + 1) * (b ? 1 : 8));
    cmp(scl_oe, 1'h0);
  endtask : half
  // low pulse of w cycles on sda; did the filtered line follow it
  task automatic glitch(input logic [1:0] f, input int w, input logic exp);
    set(6'h3f, 1'h1, f, 1'h0);
    repeat (10) @(negedge mclk);
    seen = 0;
    for (int i = 0; i < w + 12; i++) begin
      sda_low = (i < w);
      @(negedge mclk);
      if (lines.sda === 1'h0) seen = 1;
    end
    cmp(seen, 32'(exp));
  endtask : glitch

  initial begin
    repeat (20) @(negedge mclk);
    resetn = 1'h1;
    cmp(lines, 2'h3);
    half(6'h02, 1'h1);
    half(6'h3f, 1'h1);
    half(6'h00, 1'h0);
    half(6'h3f, 1'h0);
    half(6'h18, 1'h1);
    half(6'h1f, 1'h0);
    cmp(scl_o, 1'h0);
    // slave: never drives scl, follows the outside clock
    set(6'h02, 1'h1, 2'h0, 1'h0);
    run_master = 1'h1;
    hi = 0;
    n = 0;
    repeat (260) begin @(negedge mclk); hi += scl_oe; n += scl_rise; end
    run_master = 1'h0;
    cmp(hi, 0);
    cmp(n, 4);
    glitch(2'h0, 1, 1'h1);
    glitch(2'h1, 1, 1'h0);
    glitch(2'h1, 4, 1'h1);
    glitch(2'h3, 1, 1'h0);
    glitch(2'h2, 5, 1'h0);
    glitch(2'h2, 10, 1'h1);
    summarize();
  end
  // watchdog well beyond the longest run of the tests
  initial begin
    #1000000;
    fails++;
    summarize();
  end
endmodule : test_scd_clock_divider

//--- hdl/scd_clock_divider.sv
// serial clock divider with prescaler, modulus divider and scl/sda filters
`timescale 1ns/1ns
// Operation
// (RULE_01) The serial clock period is Tc*2*(modulus+1)*(7*(1-bypass)+1).
// (RULE_02) With bypass clear a divide-by-eight prescaler precedes the divider, set skips it.
// (RULE_03) The six-bit modulus 0 to 3f gives divide ratios 1 to 64 after the prescaler.
// (RULE_04) Software keeps the period between 6 and 1024 clock periods in this mode.
// (RULE_05) Filters on scl and sda are bypassed, narrow (20 ns) or wide (100 ns).
// (RULE_06) Standard 100 kHz and improved transfers up to 1000 kHz are supported.
// (RULE_07) An outside master leaves a bus free time above this slave's minimum.
// (RULE_08) At 81 MHz masters use at least 52, 56 or 62 periods per filter setting.
// (RULE_09) The period drives scl only as master; as slave scl follows the outside master.
//
// limitations and trade-offs:
// - settings are taken every cycle; software must stop the divider
//   (i_enable low) before it changes the modulus or bypass bit, or one
//   half period may come out short or long
// - the low/high phases are equal halves; any stretching by a slow
//   peer is not seen here, the shifter above handles that
// - filter depth is fixed at the wide setting; narrow reuses the
//   same counter with a lower limit to save a second set of flops
module scd_clock_divider #(
  parameter int unsigned MOD_W = 6                 // divider modulus width
) (
  input  wire logic               i_mclk,          // system clock, 50 MHz
  input  wire logic               i_resetn,        // sync reset, active low
  input  wire scd_pkg::scd_ctrl_t i_ctrl,          // clock control settings
  input  wire logic               i_enable,        // run the divider
  input  wire logic               i_scl,           // scl pin level
  input  wire logic               i_sda,           // sda pin level
  output logic                    o_scl_o,         // scl drive value (always 0)
  output logic                    o_scl_oe,        // scl pulled low while high
  output logic                    o_half_tick,     // pulse each half period
  output scd_pkg::scd_lines_t     o_lines,         // filtered scl and sda
  output logic                    o_scl_rise       // filtered scl rising edge pulse
);
  logic [2:0]       pre_q;
  logic [2:0]       pre_d;
  logic [MOD_W-1:0] div_q;
  logic [MOD_W-1:0] div_d;
  logic             scl_low_q;
  logic             half_q;
  logic             scl_f;
  logic             sda_f;
  logic             scl_f_q;
  logic             rise_q;
  logic             pre_tick;
  logic             div_end;
  logic             running;

  // settings are compared against the counters every cycle, so a
  // change mid-period can yield a short or long clock phase
  assign running  = i_enable && i_ctrl.master_mode;                  // RULE_09
  assign pre_tick = i_ctrl.prescaler_bypass || (pre_q == scd_pkg::PRESCALE_LAST); // RULE_02
  assign div_end  = pre_tick && (div_q == i_ctrl.divider_modulus);   // RULE_03
  assign pre_d    = (!running || i_ctrl.prescaler_bypass) ? 3'h0 : pre_q + 3'h1;
  assign div_d    = (!running || div_end) ? '0
                  : (pre_tick ? div_q + MOD_W'(1) : div_q);          // RULE_03

  // prescaler and modulus counters; each half period is (mod+1) prescaled ticks
  // the full range spans standard and improved bus rates
  always_ff @(posedge i_mclk) begin                                  // RULE_06
    if (!i_resetn) begin
      pre_q <= 3'h0;
      div_q <= '0;
    end else begin
      pre_q <= pre_d;                                               // RULE_02
      div_q <= div_d;                                               // RULE_01
    end
  end

  // scl phase toggles every half period; released when not master
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      scl_low_q <= 1'h0;
      half_q    <= 1'h0;
    end else begin
      scl_low_q <= running ? (scl_low_q ^ div_end) : 1'h0;           // RULE_09
      half_q    <= running && div_end;                               // RULE_01
    end
  end

  // open drain: output value is constant low, only the enable moves
  assign o_scl_o     = 1'h0;
  assign o_scl_oe    = scl_low_q;
  assign o_half_tick = half_q;

  scd_spike_filter #(.DEPTH(scd_pkg::WIDE_CYCLES)) u_scl_filt (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_line   (i_scl),
    .i_mode   (i_ctrl.filter_mode),
    .o_line   (scl_f)
  );
  scd_spike_filter #(.DEPTH(scd_pkg::WIDE_CYCLES)) u_sda_filt (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_line   (i_sda),
    .i_mode   (i_ctrl.filter_mode),
    .o_line   (sda_f)
  );

  // slave side timing comes from the filtered outside scl
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      scl_f_q    <= 1'h1;
      rise_q     <= 1'h0;
      o_lines    <= '{scl: 1'h1, sda: 1'h1};
    end else begin
      scl_f_q    <= scl_f;
      rise_q     <= scl_f && !scl_f_q;                               // RULE_09
      o_lines    <= '{scl: scl_f, sda: sda_f};                       // RULE_05
    end
  end
  assign o_scl_rise = rise_q;

  // helper: cycles since last half tick, for period checks
  logic [9:0] gap_q;
  always_ff @(posedge i_mclk) begin
    if (!i_resetn || !running || div_end) gap_q <= 10'h0;
    else gap_q <= gap_q + 10'h1;
  end

  a_half_period: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (running && $stable(i_ctrl) && div_end && $past(div_end) == 1'b0 && $past(running))
      |-> (gap_q + 10'h1) == ((10'(i_ctrl.divider_modulus) + 10'h1)
           * (i_ctrl.prescaler_bypass ? 10'h1 : 10'h8)) || gap_q < 10'h1) // RULE_01
    else $error("half period length wrong");
  a_bypass_direct: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (running && i_ctrl.prescaler_bypass && div_q == i_ctrl.divider_modulus)
      |-> div_end)                                                   // RULE_02
    else $error("bypassed divider missed its period end");
  a_prescale_gate: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (running && !i_ctrl.prescaler_bypass && pre_q != 3'h7) |-> !div_end) // RULE_02
    else $error("divider advanced without prescaler tick");
  a_slave_release: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !i_ctrl.master_mode |=> !o_scl_oe)                               // RULE_09
    else $error("scl driven while slave");
  a_toggle_half: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (running && div_end && $past(running)) |=> (o_scl_oe != $past(o_scl_oe)) && o_half_tick) // RULE_01
    else $error("scl did not toggle at half period end");
  a_modulus_bound: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    div_q <= i_ctrl.divider_modulus || !$stable(i_ctrl.divider_modulus)) // RULE_03
    else $error("divider passed its modulus");
  a_rise_pulse: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_scl_rise |=> !o_scl_rise)                                      // RULE_09
    else $error("scl rise pulse held");
  a_lines_follow: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_lines.scl == $past(scl_f))                                     // RULE_05
    else $error("filtered scl not registered");

  // filtered sda is registered the same way
  a_sda_follow: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_lines.sda == $past(sda_f))                                     // RULE_05
    else $error("filtered sda not registered");

  // stopping clears both counters so the next start is clean
  a_stop_clear: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !running |=> (div_q == '0) && (pre_q == 3'h0))                   // RULE_09
    else $error("counters not cleared while stopped");

  // prescaler steps by one every cycle while in use
  a_prescale_step: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (running && !i_ctrl.prescaler_bypass) |=> pre_q == $past(pre_q) + 3'h1) // RULE_02
    else $error("prescaler did not step");

  // prescaler parked at zero when bypassed
  a_prescale_park: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (running && i_ctrl.prescaler_bypass) |=> pre_q == 3'h0)          // RULE_02
    else $error("prescaler moved while bypassed");

  // divider holds between prescaler ticks
  a_div_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (running && !pre_tick) |=> div_q == $past(div_q))                // RULE_03
    else $error("divider moved without a tick");

  // divider steps by one on a tick before its end
  a_div_step: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (running && pre_tick && !div_end) |=> div_q == $past(div_q) + 6'h01) // RULE_03
    else $error("divider did not step on a tick");

  // scl phase holds inside a half period
  a_oe_hold: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (running && !div_end) |=> $stable(o_scl_oe))                     // RULE_01
    else $error("scl phase moved inside a half period");

  // no half ticks unless the divider runs
  a_tick_stop: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    !running |=> !o_half_tick)                                       // RULE_09
    else $error("half tick while stopped");

  // a rise pulse always comes with a high filtered scl
  a_rise_level: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_scl_rise |-> o_lines.scl)                                      // RULE_09
    else $error("rise pulse with scl low");

  c_master_run:  cover property (@(posedge i_mclk) running ##1 div_end);
  c_prescaled:   cover property (@(posedge i_mclk) running && !i_ctrl.prescaler_bypass && div_end);
  c_wide_filter: cover property (@(posedge i_mclk)
    i_ctrl.filter_mode == scd_pkg::SCD_FILT_WIDE && o_scl_rise);
  c_slave_rise:  cover property (@(posedge i_mclk)
    !i_ctrl.master_mode && o_scl_rise);
endmodule : scd_clock_divider

//--- hdl/scd_spike_filter.sv
// spike filter for one bus line, depth chosen at run time
`timescale 1ns/1ns
module scd_spike_filter #(
  parameter int unsigned DEPTH = 5                 // longest run length counted
) (
  input  wire logic               i_mclk,          // system clock
  input  wire logic               i_resetn,        // sync reset, active low
  input  wire logic               i_line,          // raw line level
  input  wire scd_pkg::scd_filter_t i_mode,        // filter setting
  output logic                    o_line           // filtered level
);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] limit;
  logic          line_q;
  logic          line_d;

  // a new level must persist past the spike width before it is taken
  assign limit = (i_mode == scd_pkg::SCD_FILT_WIDE)
               ? CW'(scd_pkg::WIDE_CYCLES) : CW'(scd_pkg::NARROW_CYCLES); // RULE_05
  always_comb begin
    line_d = line_q;
    cnt_d  = '0;
    if (i_mode == scd_pkg::SCD_FILT_BYPASS) begin
      line_d = i_line;                              // RULE_05
    end else if (i_line != line_q) begin
      if (cnt_q >= limit) begin
        line_d = i_line;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      line_q <= 1'h1;
      cnt_q  <= '0;
    end else begin
      line_q <= line_d;
      cnt_q  <= cnt_d;
    end
  end
  assign o_line = line_q;

  a_bypass_follow: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (i_mode == scd_pkg::SCD_FILT_BYPASS) |=> (line_q == $past(i_line)))  // RULE_05
    else $error("bypassed filter did not follow input");
  a_narrow_reject: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    (i_mode == scd_pkg::SCD_FILT_NARROW && $stable(i_mode) && i_line != line_q
     && $past(i_line) == line_q && $past(line_q) == line_q) |=> line_q == $past(line_q)) // RULE_05
    else $error("narrow filter passed a one cycle spike");
endmodule : scd_spike_filter

//--- inc/scd_pkg.sv
// package: constants and carriers for the serial clock divider and input filters
package scd_pkg;

  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned NARROW_SPIKE_NS  = 20;
  localparam int unsigned WIDE_SPIKE_NS    = 100;
  // filter depth in cycles: spike time rounded up, at least one cycle
  localparam int unsigned NARROW_CYCLES    =
    (NARROW_SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WIDE_CYCLES      =
    (WIDE_SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRESCALE_RATIO   = 8;
  localparam logic [5:0]  MODULUS_RESET    = 6'h3f;
  localparam logic        BYPASS_RESET     = 1'h0;
  localparam logic [2:0]  PRESCALE_LAST    = 3'h7;

  typedef enum logic [1:0] {
    SCD_FILT_BYPASS,
    SCD_FILT_NARROW,
    SCD_FILT_WIDE,
    SCD_FILT_RSVD
  } scd_filter_t;

  // clock control settings as software sets them
  typedef struct packed {
    logic [5:0]  divider_modulus;
    logic        prescaler_bypass;
    scd_filter_t filter_mode;
    logic        master_mode;
  } scd_ctrl_t;

  // filtered bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } scd_lines_t;

endpackage : scd_pkg
